// file: rtl/pohm_defs.svh
// constants of the path overhead defect monitor: offsets, fields, resets, timing
// assumes a single 250 MHz clock and an APB slave with 8-bit byte addresses
//
// Behaviour
// R1: label accepted after same C2 in 3 frames, or 5 with five-frame select.
// R2: unequipped active when accepted label is 00 and expected label is not 00.
// R3: expected 00: match only for accepted 00; unequipped stays inactive.
// R4: expected 00, accepted E1-FC: mismatch; payload defect only if equal to expected code.
// R5: expected not 00, accepted 00: mismatch, unequipped active, payload defect inactive.
// R6: expected 01: accepted 01, 02-E0, FD-FF match, no unequipped, no payload defect.
// R7: expected 02-FF: accepted 01 matches; 02-E0/FD-FF match only when equal.
// R8: expected 02-FF, accepted E1-FC: match with payload defect if equal to code.
// R9: range off: expected code is E0 plus 5-bit value; zero means none.
// R10: range on: accepted E1 up to E0 plus value counts as the expected code.
// R11: remote defect set/cleared after 5 or 10 frames of G1 bit 5 high/low.
// R12: enhanced remote set when 010,100,101,110,111 persists 5 or 10 frames.
// R13: enhanced remote cleared when 000,001,011 persists 5 or 10 frames.
// R14: all nine overhead bytes shifted out serially in arrival order J1..N1.
// R15: overhead port clock 20.736 MHz nominal, gapped from 25.92 MHz.
// R16: frame pulse high at MSB of first J1; receiver samples on rising port clock.
// R17: path alarm summary ORs section alarm and enabled path defects; here section alarm is also masked by alm_en bit 0.
// R18: defects update on frame boundaries; status readable with latched change flags.
// R19: expected 01 with accepted E1-FC behaves as expected 02-FF.
`ifndef POHM_DEFS_SVH
`define POHM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_CFG 8'h00
`define ADDR_EXPECT 8'h04
`define ADDR_ALM_EN 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_INT_STAT 8'h10
`define ADDR_INT_MASK 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CFG_LABEL5 0
`define CFG_RDI10 1
`define CFG_RANGE 2
`define CFG_W 3
`define CFG_RESET 3'h0
`define ALM_W 11
`define ALM_EN_RESET 11'h7FF
`define NDEF 6
`define D_PLU 0
`define D_PLM 1
`define D_UNEQ 2
`define D_PDI 3
`define D_RDI 4
`define D_ERDI 5
`define STATUS_LABEL_LSB 16
`define EXPECT_CODE_LSB 8

// ----------------------------------------------------------------
// overhead byte positions and persistence counts
// ----------------------------------------------------------------
`define IDX_J1 4'h0
`define IDX_C2 4'h2
`define IDX_G1 4'h3
`define IDX_N1 4'h8
`define POH_BYTES 9
`define LABEL_N3 3'h3
`define LABEL_N5 3'h5
`define PLU_LIMIT 3'h5
`define RDI_N5 4'h5
`define RDI_N10 4'hA
`define PDI_BASE 8'hE0
`define PDI_LOW 8'hE1
`define PDI_HIGH 8'hFC

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ 250000
`define OH_BASE_KHZ 25920
`define OH_PORT_KHZ 20736
`define OH_GAP_PERIOD 3'h5

`endif

// file: rtl/pohm_pkg.sv
// types shared by the path overhead monitor and its serial port
// assumes pohm_defs.svh on the include path
`include "pohm_defs.svh"

package pohm_pkg;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    ser_state_t st;
    logic [8*`POH_BYTES-1:0] buf_bytes;
    logic [8*`POH_BYTES-1:0] shreg;
    logic [6:0] bit_cnt;
    logic [31:0] phase;
    logic [2:0] gap_cnt;
    logic [3:0] half_cnt;
    logic oh_clk;
    logic oh_data;
    logic oh_fp;
  } ser_reg_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [`CFG_W-1:0] cfg;
    logic [7:0] exp_label;
    logic [4:0] exp_code;
    logic [`ALM_W-1:0] alm_en;
    logic [`NDEF-1:0] int_stat;
    logic [`NDEF-1:0] int_mask;
    logic irq;
    logic alarm;
    logic [7:0] c2_cur;
    logic [7:0] g1_cur;
    logic [7:0] c2_prev;
    logic [2:0] c2_run;
    logic [7:0] acc_label;
    logic acc_valid;
    logic [2:0] plu_cnt;
    logic [2:0] g1_prev;
    logic [3:0] g1_run;
    logic [3:0] rdi_run;
    logic [`NDEF-1:0] defects;
  } mon_reg_t;

endpackage : pohm_pkg

// file: rtl/poh_serializer.sv
// serial overhead port: byte store, gapped port clock and bit shifter
// assumes bytes arrive on CLK with an index 0..NBYTES-1 and frame_go with the last
`timescale 1ns/1ps
`include "pohm_defs.svh"

module poh_serializer
#(
  parameter int NBYTES = `POH_BYTES,
  parameter int CLK_KHZ = `CLK_KHZ
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte capture
  input wire logic byte_we,
  input wire logic [3:0] byte_idx,
  input wire logic [7:0] byte_data,
  input wire logic frame_go,
  // serial port
  output logic oh_clk,
  output logic oh_data,
  output logic oh_fp
);
  import pohm_pkg::*;

  localparam logic [31:0] PHASE_INC =
    32'(({32'd0, 32'(`OH_BASE_KHZ)} << 32) / 64'(CLK_KHZ));
  localparam int HALF_CYC_I = CLK_KHZ / (2 * `OH_BASE_KHZ);
  localparam logic [3:0] HALF_CYC = 4'(HALF_CYC_I < 1 ? 1 : HALF_CYC_I);
  localparam logic [6:0] LAST_BIT = 7'(8 * NBYTES - 1);

  // the byte store is sized for the full overhead column
  if (NBYTES < 1 || NBYTES > `POH_BYTES || CLK_KHZ < 4 * `OH_BASE_KHZ || HALF_CYC_I > 15)
  begin : g_param_check
    $error("poh_serializer: unsupported NBYTES or CLK_KHZ");
  end

  ser_reg_t q, d;
  logic [32:0] phase_sum;
  logic tick;
  logic gap_ok;

  always_comb
  begin
    d = q;
    phase_sum = {1'b0, q.phase} + {1'b0, PHASE_INC};
    tick = phase_sum[32];
    gap_ok = 1'b0;
    d.phase = phase_sum[31:0];
    if (byte_we && byte_idx < 4'(NBYTES))
      d.buf_bytes[8*(NBYTES-1-int'(byte_idx)) +: 8] = byte_data; // R14
    if (q.half_cnt != 4'h0)
    begin
      d.half_cnt = q.half_cnt - 4'h1;
      if (q.half_cnt == 4'h1)
        d.oh_clk = 1'b1;
    end
    // 25.92 MHz ticks with one of every five dropped: 20.736 MHz nominal
    if (tick)
    begin
      d.gap_cnt = (q.gap_cnt == `OH_GAP_PERIOD - 3'h1) ? 3'h0 : q.gap_cnt + 3'h1; // R15
      gap_ok = (q.gap_cnt != `OH_GAP_PERIOD - 3'h1); // R15
    end
    if (gap_ok)
    begin
      d.oh_clk = 1'b0; // R15
      d.half_cnt = HALF_CYC;
      d.oh_fp = 1'b0;
      d.oh_data = 1'b0;
      case (q.st)
        SER_IDLE:
        begin
          d.st = SER_IDLE;
        end
        SER_SHIFT:
        begin
          // data changes on the falling edge, stable at the rising one
          d.oh_data = q.shreg[8*NBYTES-1]; // R14
          d.oh_fp = (q.bit_cnt == 7'h0); // R16
          d.shreg = q.shreg << 1;
          d.bit_cnt = q.bit_cnt + 7'h1;
          if (q.bit_cnt == LAST_BIT)
            d.st = SER_IDLE;
        end
        default:
        begin
          d.st = SER_IDLE;
        end
      endcase
    end
    // a frame arriving mid-shift is dropped: frames are far longer than the shift
    if (frame_go && q.st == SER_IDLE)
    begin
      d.st = SER_SHIFT;
      d.shreg = d.buf_bytes;
      d.bit_cnt = 7'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= SER_IDLE;
      q.oh_clk <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign oh_clk = q.oh_clk;
  assign oh_data = q.oh_data;
  assign oh_fp = q.oh_fp;

endmodule : poh_serializer

// file: rtl/path_overhead_defect_monitor.sv
// receive high-order path overhead monitor with APB registers
// assumes overhead bytes and defect inputs come from logic on CLK
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "pohm_defs.svh"

module path_overhead_defect_monitor
#(
  parameter int CLK_KHZ = `CLK_KHZ
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // overhead byte stream
  input wire logic POH_VALID,
  input wire logic [3:0] POH_INDEX,
  input wire logic [7:0] POH_BYTE,
  // defects from neighbouring blocks
  input wire logic SECTION_ALARM_SUMMARY,
  input wire logic PATH_AIS,
  input wire logic PATH_LOP,
  input wire logic PATH_TRACE_UNSTABLE,
  input wire logic PATH_TRACE_MISMATCH,
  // alarm and interrupt
  output logic PATH_ALARM_SUMMARY,
  output logic IRQ,
  // serial overhead port
  output logic OVERHEAD_PORT_CLOCK,
  output logic OVERHEAD_SERIAL_OUTPUT,
  output logic OVERHEAD_FRAME_PULSE
);
  import pohm_pkg::*;

  // the port clock needs a few system clocks per half period
  if (CLK_KHZ < 4 * `OH_BASE_KHZ)
  begin : g_clk_check
    $error("path_overhead_defect_monitor: CLK_KHZ too low for the overhead port");
  end

  // ----------------------------------------------------------------
  // label judgement
  // ----------------------------------------------------------------
  // returns {mismatch, unequipped, payload_defect}
  function automatic logic [2:0] judge_label(input logic [7:0] expected_label,
                                             input logic [7:0] accepted_label,
                                             input logic [4:0] code,
                                             input logic range_en);
    logic [7:0] expected_defect_code;
    logic is_pdi;
    logic pdi_hit;
    logic [2:0] r;
    expected_defect_code = `PDI_BASE + {3'h0, code}; // R9
    is_pdi = (accepted_label >= `PDI_LOW) && (accepted_label <= `PDI_HIGH);
    if (code == 5'h00)
    begin
      pdi_hit = 1'b0; // R9
    end
    else if (range_en)
    begin
      pdi_hit = (accepted_label >= `PDI_LOW) &&
                (accepted_label <= expected_defect_code); // R10
    end
    else
    begin
      pdi_hit = (accepted_label == expected_defect_code); // R9
    end
    r = 3'b000;
    if (expected_label == 8'h00)
    begin
      r[2] = (accepted_label != 8'h00); // R3
      r[0] = is_pdi & pdi_hit; // R4
    end
    else if (accepted_label == 8'h00)
    begin
      r = 3'b110; // R2 R5
    end
    else if (accepted_label == 8'h01)
    begin
      r = 3'b000; // R6 R7
    end
    else if (is_pdi)
    begin
      // expected 01 follows the 02-FF behaviour here
      r[2] = ~pdi_hit; // R8 R19
      r[0] = pdi_hit; // R8 R19
    end
    else
    begin
      r[2] = (expected_label != 8'h01) && (accepted_label != expected_label); // R6 R7
    end
    return r;
  endfunction : judge_label

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mon_reg_t q, d;
  logic access;
  logic wr_commit;
  logic frame_end;
  logic [2:0] label_need;
  logic [3:0] frames_need;
  logic [2:0] run_c2;
  logic [2:0] run_g1_pat;
  logic [3:0] run_g1;
  logic [2:0] verdict;
  logic [`NDEF-1:0] new_def;
  logic [`NDEF-1:0] w1c;
  logic [`NDEF-1:0] changed;
  logic [`ALM_W-1:0] alm_src;
  logic [31:0] rd_val;
  logic rd_err;

  always_comb
  begin
    d = q;
    access = PSEL & PENABLE;
    wr_commit = access & q.pready & PWRITE;
    frame_end = POH_VALID && (POH_INDEX == `IDX_N1);
    label_need = q.cfg[`CFG_LABEL5] ? `LABEL_N5 : `LABEL_N3; // R1
    frames_need = q.cfg[`CFG_RDI10] ? `RDI_N10 : `RDI_N5; // R11
    run_c2 = 3'h0;
    run_g1_pat = 3'h0;
    run_g1 = 4'h0;
    verdict = 3'h0;
    new_def = q.defects;
    w1c = '0;
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;

    // ----------------------------------------------------------------
    // apb: one wait state, read data registered with pready
    // ----------------------------------------------------------------
    d.pready = access & ~q.pready;
    if (access & ~q.pready)
    begin
      case (PADDR)
        `ADDR_CFG:
        begin
          rd_val = {29'h0, q.cfg};
        end
        `ADDR_EXPECT:
        begin
          rd_val = {19'h0, q.exp_code, q.exp_label};
        end
        `ADDR_ALM_EN:
        begin
          rd_val = {21'h0, q.alm_en};
        end
        `ADDR_STATUS:
        begin
          rd_val = {8'h0, q.acc_label, 9'h0, q.acc_valid, q.defects}; // R18
        end
        `ADDR_INT_STAT:
        begin
          rd_val = {26'h0, q.int_stat}; // R18
        end
        `ADDR_INT_MASK:
        begin
          rd_val = {26'h0, q.int_mask};
        end
        default:
        begin
          rd_err = 1'b1;
        end
      endcase
      d.prdata = rd_val;
      d.pslverr = rd_err;
    end
    else
    begin
      d.prdata = 32'h0000_0000;
      d.pslverr = 1'b0;
    end
    if (wr_commit)
    begin
      case (PADDR)
        `ADDR_CFG:
        begin
          d.cfg = PWDATA[`CFG_W-1:0];
        end
        `ADDR_EXPECT:
        begin
          d.exp_label = PWDATA[7:0];
          d.exp_code = PWDATA[`EXPECT_CODE_LSB +: 5];
        end
        `ADDR_ALM_EN:
        begin
          d.alm_en = PWDATA[`ALM_W-1:0]; // R17
        end
        `ADDR_INT_STAT:
        begin
          w1c = PWDATA[`NDEF-1:0];
        end
        `ADDR_INT_MASK:
        begin
          d.int_mask = PWDATA[`NDEF-1:0];
        end
        default:
        begin
          d.cfg = q.cfg;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // overhead capture and per-frame defect update
    // ----------------------------------------------------------------
    if (POH_VALID && POH_INDEX == `IDX_C2)
    begin
      d.c2_cur = POH_BYTE;
    end
    if (POH_VALID && POH_INDEX == `IDX_G1)
    begin
      d.g1_cur = POH_BYTE;
    end
    if (frame_end)
    begin
      // label persistence and instability counter
      run_c2 = (q.c2_cur == q.c2_prev) ?
               ((q.c2_run == `LABEL_N5) ? q.c2_run : q.c2_run + 3'h1) : 3'h1;
      d.c2_run = run_c2;
      d.c2_prev = q.c2_cur;
      if (q.c2_cur != q.c2_prev && q.plu_cnt != `PLU_LIMIT)
        d.plu_cnt = q.plu_cnt + 3'h1;
      if (run_c2 >= label_need)
      begin
        d.acc_label = q.c2_cur; // R1
        d.acc_valid = 1'b1; // R1
        d.plu_cnt = 3'h0;
      end
      new_def[`D_PLU] = (d.plu_cnt == `PLU_LIMIT);
      // label verdict on the freshly accepted value
      verdict = judge_label(q.exp_label, d.acc_label, q.exp_code, q.cfg[`CFG_RANGE]);
      new_def[`D_PLM] = d.acc_valid & verdict[2]; // R18
      new_def[`D_UNEQ] = d.acc_valid & verdict[1]; // R2
      new_def[`D_PDI] = d.acc_valid & verdict[0]; // R18
      // remote defect: count frames that disagree with the present state
      if (q.g1_cur[3] != q.defects[`D_RDI])
      begin
        if (q.rdi_run + 4'h1 >= frames_need)
        begin
          new_def[`D_RDI] = q.g1_cur[3]; // R11
          d.rdi_run = 4'h0;
        end
        else
        begin
          d.rdi_run = q.rdi_run + 4'h1;
        end
      end
      else
      begin
        d.rdi_run = 4'h0;
      end
      // enhanced remote defect: identical bits 5-7 pattern persistence
      run_g1_pat = q.g1_cur[3:1];
      run_g1 = (run_g1_pat == q.g1_prev) ?
               ((q.g1_run == `RDI_N10) ? q.g1_run : q.g1_run + 4'h1) : 4'h1;
      d.g1_run = run_g1;
      d.g1_prev = run_g1_pat;
      if (run_g1 >= frames_need)
      begin
        case (run_g1_pat)
          3'b010, 3'b100, 3'b101, 3'b110, 3'b111:
          begin
            new_def[`D_ERDI] = 1'b1; // R12
          end
          default:
          begin
            new_def[`D_ERDI] = 1'b0; // R13
          end
        endcase
      end
    end
    d.defects = new_def; // R18

    // ----------------------------------------------------------------
    // change flags and interrupt: a new change beats a clear
    // ----------------------------------------------------------------
    changed = new_def ^ q.defects;
    for (int i = 0; i < `NDEF; i++)
    begin
      d.int_stat[i] = changed[i] | (q.int_stat[i] & ~w1c[i]); // R18
    end
    d.irq = |(d.int_stat & d.int_mask);

    // ----------------------------------------------------------------
    // alarm summary
    // ----------------------------------------------------------------
    alm_src = {PATH_TRACE_MISMATCH, PATH_TRACE_UNSTABLE,
               new_def[`D_ERDI], new_def[`D_RDI], new_def[`D_PDI],
               new_def[`D_UNEQ], new_def[`D_PLM], new_def[`D_PLU],
               PATH_LOP, PATH_AIS, SECTION_ALARM_SUMMARY};
    d.alarm = |(alm_src & q.alm_en); // R17
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      q <= '0;
      q.cfg <= `CFG_RESET;
      q.alm_en <= `ALM_EN_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // serial overhead port
  // ----------------------------------------------------------------
  poh_serializer
  #(
    .NBYTES(`POH_BYTES),
    .CLK_KHZ(CLK_KHZ)
  )
  u_ser
  (
    .clk(CLK),
    .rst_n(RST_N),
    .byte_we(POH_VALID),
    .byte_idx(POH_INDEX),
    .byte_data(POH_BYTE),
    .frame_go(frame_end), // R14
    .oh_clk(OVERHEAD_PORT_CLOCK),
    .oh_data(OVERHEAD_SERIAL_OUTPUT),
    .oh_fp(OVERHEAD_FRAME_PULSE)
  );

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign IRQ = q.irq;
  assign PATH_ALARM_SUMMARY = q.alarm;

endmodule : path_overhead_defect_monitor

// file: tb/poh_source.sv
// upstream overhead source: one frame of nine bytes per go pulse
// assumes go is a one-cycle request taken on the rising edge of clk
`timescale 1ns/1ps

module poh_source
(
  // clock
  input wire logic clk,
  // request
  input wire logic go,
  input wire logic [71:0] bytes,
  output logic busy,
  // overhead stream
  output logic valid,
  output logic [3:0] index,
  output logic [7:0] data
);
  logic [71:0] sh_q;
  logic [3:0] cnt_q;

  initial
  begin
    busy = 1'b0;
    valid = 1'b0;
    index = 4'h0;
    data = 8'h00;
  end

  // released lines flip so that no stale byte looks valid
  always @(posedge clk)
  begin
    valid <= busy;
    data <= busy ? sh_q[71:64] : ~data;
    index <= busy ? cnt_q : ~index;
    if (busy)
    begin
      sh_q <= sh_q << 8;
      cnt_q <= cnt_q + 4'h1;
      busy <= cnt_q != 4'h8;
    end
    else if (go)
    begin
      sh_q <= bytes;
      cnt_q <= 4'h0;
      busy <= 1'b1;
    end
  end
endmodule : poh_source

// file: tb/pohm_props_props.sv
// port checker of the path overhead monitor
// assumes it is bound into the monitor top
`timescale 1ns/1ps

module pohm_props
(
  // watched ports
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic OVERHEAD_PORT_CLOCK,
  input wire logic OVERHEAD_SERIAL_OUTPUT,
  input wire logic OVERHEAD_FRAME_PULSE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ONE_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("access not answered after one wait");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready outside an access phase");
  AST_DATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
    else $error("read data not zero while idle");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_DATA_ON_FALL: assert property ($changed(OVERHEAD_SERIAL_OUTPUT) |-> $fell(OVERHEAD_PORT_CLOCK))
    else $error("serial data moved off the falling port clock");
  AST_PULSE_ON_FALL: assert property ($changed(OVERHEAD_FRAME_PULSE) |-> $fell(OVERHEAD_PORT_CLOCK))
    else $error("frame pulse moved off the falling port clock");
  AST_CLK_LOW_FOUR: assert property ($fell(OVERHEAD_PORT_CLOCK) |=> !OVERHEAD_PORT_CLOCK [*3] ##1 OVERHEAD_PORT_CLOCK)
    else $error("port clock low time wrong");
  AST_CLK_RUNS: assert property ($rose(OVERHEAD_PORT_CLOCK) |-> ##[1:20] $fell(OVERHEAD_PORT_CLOCK))
    else $error("port clock stopped high");
  AST_PULSE_ONE_BIT: assert property ($rose(OVERHEAD_FRAME_PULSE) |-> ##[8:24] $fell(OVERHEAD_FRAME_PULSE))
    else $error("frame pulse not one bit long");
endmodule : pohm_props

bind path_overhead_defect_monitor pohm_props u_props (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .OVERHEAD_PORT_CLOCK(OVERHEAD_PORT_CLOCK), .OVERHEAD_SERIAL_OUTPUT(OVERHEAD_SERIAL_OUTPUT),
  .OVERHEAD_FRAME_PULSE(OVERHEAD_FRAME_PULSE));

// file: tb/tb_top.sv
// self-checking bench of the path overhead defect monitor
// assumes the source model and the bound checker are compiled first
`timescale 1ns/1ps
`include "pohm_defs.svh"

module tb_top;
  import pohm_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  note_t nq[$];
  note_t n;
  logic [71:0] sq[$];
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, arm = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h0000_a28e;
  logic pready, pslverr, pv, alarm, irq, ocl, osd, ofp, busy;
  logic [3:0] pi;
  logic [7:0] pb;
  logic [4:0] ext = 0;
  logic [1:0] pr = 2'b00;
  logic [71:0] fb = 0, cap = 0;
  int err_total = 0, num_checks = 0, cyc = 0, nb = 0;
  int ab[5] = '{0, 1, 2, 9, 10};

  initial forever #2 clk = ~clk;

  poh_source src (.clk(clk), .go(go), .bytes(fb), .busy(busy), .valid(pv), .index(pi), .data(pb));
  path_overhead_defect_monitor dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .POH_VALID(pv), .POH_INDEX(pi), .POH_BYTE(pb),
    .SECTION_ALARM_SUMMARY(ext[0]), .PATH_AIS(ext[1]), .PATH_LOP(ext[2]),
    .PATH_TRACE_UNSTABLE(ext[3]), .PATH_TRACE_MISMATCH(ext[4]), .PATH_ALARM_SUMMARY(alarm),
    .IRQ(irq), .OVERHEAD_PORT_CLOCK(ocl), .OVERHEAD_SERIAL_OUTPUT(osd),
    .OVERHEAD_FRAME_PULSE(ofp));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected {payload defect, unequipped, mismatch}
  function automatic logic [2:0] lbl(input logic [7:0] e, input logic [7:0] a,
                                     input logic [4:0] c, input logic g);
    logic p;
    logic q;
    p = c != 0 && (g ? a >= 8'he1 && a <= 8'he0 + c : a == 8'he0 + c);
    q = a >= 8'he1 && a <= 8'hfc;
    if (a == 0) return {1'b0, e != 0, e != 0};
    if (e == 0) return {q && p, 1'b0, 1'b1};
    if (q) return {p, 1'b0, !p};
    return {2'b00, a != 1 && e != 1 && a != e};
  endfunction : lbl

  task automatic cmp(input logic [71:0] g, input logic [71:0] x);
    num_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // one transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic [31:0] m);
    nq.push_back('{x, m, a > `ADDR_INT_MASK});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0, x, m);
  endtask : rd

  task automatic wt();
    repeat (3) @(posedge clk);
  endtask : wt

  task automatic frames(input logic [7:0] c2, input logic [7:0] g1, input int k);
    repeat (k)
    begin
      fb <= {16'(rnd()), c2, g1, rnd(), 8'(rnd())};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
    end
  endtask : frames

  task automatic tbl(input logic [7:0] e, input logic [7:0] a, input logic [4:0] c,
                     input logic g);
    wr(`ADDR_CFG, {29'h0, g, 2'b00});
    wr(`ADDR_EXPECT, {19'h0, c, e});
    frames(a, 8'h00, 3);
    rd(`ADDR_STATUS, {8'h00, a, 12'h004, lbl(e, a, c, g), 1'b0}, 32'h00ff_004e);
  endtask : tbl

  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  always @(negedge clk)
    if (pready === 1'b1)
    begin
      n = nq.pop_front();
      cmp(prdata & n.m, n.d);
      cmp(pslverr, n.e);
    end

  always @(posedge ocl)
    if (arm)
    begin
      cap = {cap[70:0], osd};
      nb = ofp === 1'b1 ? 1 : nb + (nb > 0);
      if (nb == 72)
      begin
        cmp(cap, sq.pop_front());
        arm = 1'b0;
        nb = 0;
      end
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), i == 2 ? 32'h0000_07ff : 32'h0, 32'hffff_ffff);
    wr(8'h18, 32'hffff_ffff);
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      ext <= 5'(1 << i);
      wt();
      cmp(alarm, 1);
      wr(`ADDR_ALM_EN, 32'h0000_07ff ^ (32'h1 << ab[i]));
      wt();
      cmp(alarm, 0);
      ext <= 5'h00;
      wr(`ADDR_ALM_EN, 32'h0000_07ff);
    end
    $display("test alarm done");
    wr(`ADDR_EXPECT, 32'h0000_0013);
    frames(8'h13, 8'h00, 2);
    rd(`ADDR_STATUS, 32'h0, 32'h0000_0040);
    frames(8'h13, 8'h00, 1);
    rd(`ADDR_STATUS, 32'h0013_0040, 32'h00ff_0042);
    wr(`ADDR_CFG, 32'h1);
    frames(8'h77, 8'h00, 4);
    rd(`ADDR_STATUS, 32'h0013_0040, 32'h00ff_0040);
    frames(8'h77, 8'h00, 1);
    rd(`ADDR_STATUS, 32'h0077_0042, 32'h00ff_0042);
    $display("test acceptance done");
    for (int i = 0; i < 18; i++)
      tbl(i < 6 ? 8'h00 : i < 12 ? 8'h01 : 8'h35, i % 6 == 0 ? 8'h00 : i % 6 == 1 ? 8'h01 :
          i % 6 == 2 ? 8'h35 : i % 6 == 3 ? 8'he5 : i % 6 == 4 ? 8'hfe : 8'(rnd()),
          5'h05, 1'b0);
    for (int i = 0; i < 6; i++)
      tbl(8'h35, 8'(8'he1 + rnd() % 28), i == 0 ? 5'h00 : i == 1 ? 5'h1c : 5'(rnd() % 29),
          i[0]);
    $display("test label table done");
    wr(`ADDR_CFG, 32'h0);
    wr(`ADDR_EXPECT, 32'h0000_0013);
    for (int i = 0; i < 8; i++)
    begin
      frames(8'h13, {4'h0, 3'(i), 1'b0}, 4);
      rd(`ADDR_STATUS, {26'h0, pr, 4'h0}, 32'h0000_0030);
      frames(8'h13, {4'h0, 3'(i), 1'b0}, 1);
      pr = {i == 2 || i > 3, i[2]};
      rd(`ADDR_STATUS, {26'h0, pr, 4'h0}, 32'h0000_0030);
    end
    wr(`ADDR_CFG, 32'h2);
    frames(8'h13, 8'h02, 9);
    rd(`ADDR_STATUS, 32'h0000_0030, 32'h0000_0030);
    frames(8'h13, 8'h02, 1);
    rd(`ADDR_STATUS, 32'h0, 32'h0000_0030);
    $display("test remote defect done");
    wr(`ADDR_INT_MASK, 32'h0);
    wr(`ADDR_INT_STAT, 32'h3f);
    wr(`ADDR_EXPECT, 32'h0000_0014);
    frames(8'h13, 8'h02, 1);
    wt();
    cmp(irq, 0);
    cmp(alarm, 1);
    wr(`ADDR_STATUS, 32'hffff_ffff);
    rd(`ADDR_STATUS, 32'h0013_0042, 32'h00ff_007f);
    rd(`ADDR_INT_STAT, 32'h2, 32'h3f);
    wr(`ADDR_INT_MASK, 32'h2);
    wt();
    cmp(irq, 1);
    wr(`ADDR_ALM_EN, 32'h0000_07ef);
    wt();
    cmp(alarm, 0);
    wr(`ADDR_INT_STAT, 32'h2);
    wt();
    cmp(irq, 0);
    rd(`ADDR_INT_STAT, 32'h0, 32'h3f);
    for (int i = 0; i < 5; i++)
      frames(8'(8'h20 + i), 8'h02, 1);
    rd(`ADDR_STATUS, 32'h1, 32'h1);
    cmp(alarm, 1);
    $display("test interrupt done");
    repeat (1000) @(posedge clk);
    arm = 1'b1;
    frames(8'h13, 8'h00, 1);
    sq.push_back(fb);
    while (arm) @(posedge clk);
    $display("test serial port done");
    end_of_test();
  end
endmodule : tb_top
